// *** logic/hpwc_noise_filter.sv ***
/*
 * hpwc_noise_filter: digital noise filter for the capture input pin.
 * assumes: pin is synchronous to mclk_in; sampled on every undivided clock.
 */
`default_nettype none

module hpwc_noise_filter
	import hpwc_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	input  wire logic pin_in,
	output var  logic level_out
);

	hpwc_flt_state_type s_r;
	hpwc_flt_state_type s_nxt;

	// level follows only once all recent samples agree
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.samples = {s_r.samples[FLT_SAMPLES-2:0], pin_in};
		if (&s_r.samples)
		begin
			s_nxt.level = 1'b1;
		end
		else if (~|s_r.samples)
		begin
			s_nxt.level = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_r <= '0;
		end
		else if (ce_in)
		begin
			s_r <= s_nxt;
		end
	end

	assign level_out = s_r.level;

endmodule : hpwc_noise_filter

`default_nettype wire

// *** logic/hpwc_pkg.sv ***
/*
 * hpwc_pkg: constants, register map and carrier types of the high pulse
 * width capture channel.
 * assumes: a single 200 MHz clock that also serves as the peripheral clock.
 */
`default_nettype none

package hpwc_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned EVT_W  = 2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_START   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_COUNT   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CAPTURE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_PIN     = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_GROUP   = 8'h1C;

	// field positions
	localparam int unsigned START_BIT   = 0;
	localparam int unsigned EVT_CAP_BIT = 0;
	localparam int unsigned EVT_OVF_BIT = 1;
	localparam int unsigned PIN_BIT     = 0;
	localparam int unsigned GROUP_BIT   = 0;

	// values after reset
	localparam logic             START_RST  = 1'b0;
	localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;
	localparam logic [CNT_W-1:0] CAP_RST    = 16'h0000;
	localparam logic [EVT_W-1:0] STATUS_RST = 2'h0;
	localparam logic [EVT_W-1:0] MASK_RST   = 2'h0;

	// counter limits
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

	// count clock prescaler: peripheral clock divided by four
	localparam int unsigned PRE_DIV  = 4;
	localparam int unsigned PRE_W    = 2;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_DIV - 1);

	// noise filter: equal samples needed, taken every peripheral clock
	localparam int unsigned FLT_SAMPLES = 3;

	// pending source codes, highest priority first
	localparam logic [1:0] PEND_NONE = 2'h0;
	localparam logic [1:0] PEND_OVF  = 2'h1;
	localparam logic [1:0] PEND_CAP  = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} hpwc_bus_req_type;

	typedef struct packed {
		logic                   start;
		logic [PRE_W-1:0]       pre;
		logic [CNT_W-1:0]       cnt;
		logic [CNT_W-1:0]       cap;
		logic [EVT_W-1:0]       status;
		logic [EVT_W-1:0]       mask;
		logic                   pin_prev;
		logic [DATA_W-1:0]      rdata;
		logic                   irq;
	} hpwc_state_type;

	typedef struct packed {
		logic [FLT_SAMPLES-1:0] samples;
		logic                   level;
	} hpwc_flt_state_type;

endpackage : hpwc_pkg

`default_nettype wire

// *** logic/hpwc_top.sv ***
/*
 * hpwc_top: one timer channel measuring high pulse width by capture on
 * both edges of a filtered pin, with overflow and capture interrupts.
 * assumes: plain register port, read data one cycle after the read strobe;
 * capture pin synchronous to mclk_in; ce_in high for normal operation.
 */
// Chosen here: the plain strobed port and the register addresses.
`default_nettype none

module hpwc_top
	import hpwc_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	input  wire logic              ce_in,
	input  wire hpwc_bus_req_type  bus_in,
	input  wire logic              capture_input_pin_in,
	output var  logic [DATA_W-1:0] rd_data_out,
	output var  logic              irq_out
);

	hpwc_state_type s_r;
	hpwc_state_type s_nxt;

	logic             pin_filtered;
	logic             count_tick;
	logic             pin_edge;
	logic             capture_evt;
	logic             overflow_evt;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic [EVT_W-1:0] pending;
	logic [1:0]       pend_code;
	logic [DATA_W-1:0] rd_mux;
	logic             wr_start;
	logic             wr_status;
	logic             wr_mask;

	// filtered capture pin
	hpwc_noise_filter u_filter
	(
		.mclk_in   (mclk_in),
		.rst_n_in  (rst_n_in),
		.ce_in     (ce_in),
		.pin_in    (capture_input_pin_in),
		.level_out (pin_filtered)
	);

	// register write decode
	always_comb
	begin
		wr_start  = bus_in.wr && (bus_in.addr == OFF_START);
		wr_status = bus_in.wr && (bus_in.addr == OFF_STATUS);
		wr_mask   = bus_in.wr && (bus_in.addr == OFF_MASK);
	end

	// count clock: peripheral clock divided by four
	always_comb
	begin
		count_tick = s_r.start && (s_r.pre == PRE_LAST);
	end

	// edge detection on the filtered level, both directions
	always_comb
	begin
		pin_edge = pin_filtered != s_r.pin_prev;
	end

	// capture and overflow events
	always_comb
	begin
		capture_evt  = s_r.start && pin_edge;
		// a simultaneous clear wins over the wrap
		overflow_evt = count_tick && (s_r.cnt == CNT_MAX)
			&& !capture_evt;
	end

	// sticky event sets and write-one clears
	always_comb
	begin
		evt_set = '0;
		evt_set[EVT_CAP_BIT] = capture_evt;
		evt_set[EVT_OVF_BIT] = overflow_evt;
		evt_clr = '0;
		if (wr_status)
		begin
			evt_clr = bus_in.wdata[EVT_W-1:0];
		end
	end

	// unmasked pending requests and priority resolution
	always_comb
	begin
		pending = s_r.status & s_r.mask;
		if (pending[EVT_OVF_BIT])
		begin
			pend_code = PEND_OVF;
		end
		else if (pending[EVT_CAP_BIT])
		begin
			pend_code = PEND_CAP;
		end
		else
		begin
			pend_code = PEND_NONE;
		end
	end

	// read data multiplexer, unmapped addresses read zero
	always_comb
	begin
		rd_mux = '0;
		unique case (bus_in.addr)
			OFF_START:
			begin
				rd_mux[START_BIT] = s_r.start;
			end
			OFF_COUNT:
			begin
				rd_mux[CNT_W-1:0] = s_r.cnt;
			end
			OFF_CAPTURE:
			begin
				rd_mux[CNT_W-1:0] = s_r.cap;
			end
			OFF_STATUS:
			begin
				rd_mux[EVT_W-1:0] = s_r.status;
			end
			OFF_MASK:
			begin
				rd_mux[EVT_W-1:0] = s_r.mask;
			end
			OFF_PIN:
			begin
				rd_mux[PIN_BIT] = pin_filtered;
			end
			OFF_PENDING:
			begin
				rd_mux[1:0] = pend_code;
			end
			OFF_GROUP:
			begin
				rd_mux[GROUP_BIT] = s_r.status[EVT_OVF_BIT];
			end
			default:
			begin
				rd_mux = '0;
			end
		endcase
	end

	// next state of the whole channel
	always_comb
	begin
		s_nxt = s_r;

		// count start bit
		if (wr_start)
		begin
			s_nxt.start = bus_in.wdata[START_BIT];
		end

		// prescaler runs only while counting
		if (s_r.start)
		begin
			s_nxt.pre = s_r.pre + PRE_W'(1);
		end
		else
		begin
			s_nxt.pre = '0;
		end

		// filtered level history
		s_nxt.pin_prev = pin_filtered;

		// channel counter, standalone up-counting
		if (capture_evt)
		begin
			s_nxt.cap = s_r.cnt;
			s_nxt.cnt = '0;
		end
		else if (count_tick)
		begin
			// wraps to zero past the maximum
			s_nxt.cnt = s_r.cnt + CNT_W'(1);
		end

		// status: hardware set wins over software clear
		s_nxt.status = (s_r.status & ~evt_clr) | evt_set;

		// interrupt mask
		if (wr_mask)
		begin
			s_nxt.mask = bus_in.wdata[EVT_W-1:0];
		end

		// read data stands only in the cycle after the strobe
		if (bus_in.rd)
		begin
			s_nxt.rdata = rd_mux;
		end
		else
		begin
			s_nxt.rdata = '0;
		end

		// level interrupt from the next status and mask
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
	end

	// state register, frozen while ce_in is low
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_r.start    <= START_RST;
			s_r.pre      <= '0;
			s_r.cnt      <= CNT_RST;
			s_r.cap      <= CAP_RST;
			s_r.status   <= STATUS_RST;
			s_r.mask     <= MASK_RST;
			s_r.pin_prev <= 1'b0;
			s_r.rdata    <= '0;
			s_r.irq      <= 1'b0;
		end
		else if (ce_in)
		begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flip-flops
	assign rd_data_out = s_r.rdata;
	assign irq_out     = s_r.irq;

endmodule : hpwc_top

`default_nettype wire

// *** verif/hpwc_assertions.sv ***
/*
 * hpwc_assertions: port checker of the capture channel.
 * assumes: bound to hpwc_top; offsets of the package map.
 */
`default_nettype none

module hpwc_assertions
	import hpwc_pkg::*;
(
	input wire logic              mclk_in,
	input wire logic              rst_n_in,
	input wire logic              ce_in,
	input wire hpwc_bus_req_type  bus_in,
	input wire logic              capture_input_pin_in,
	input wire logic [DATA_W-1:0] rd_data_out,
	input wire logic              irq_out
);
	logic [1:0] msk_r;
	logic       run_r;
	logic       wr_c;
	logic       rd_c;
	logic       mw_c;
	assign wr_c = bus_in.wr && ce_in;
	assign rd_c = bus_in.rd && ce_in;
	assign mw_c = wr_c && bus_in.addr == OFF_MASK;
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			msk_r <= 2'h0;
			run_r <= 1'b0;
		end
		else if (mw_c)
			msk_r <= bus_in.wdata[1:0];
		else if (wr_c && bus_in.addr == OFF_START)
			run_r <= bus_in.wdata[0];
	end
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	a_start_read: assert property (
		$past(rd_c && bus_in.addr == OFF_START)
		|-> rd_data_out == 32'($past(run_r))) else $error("start readback");
	a_mask_read: assert property (
		$past(rd_c && bus_in.addr == OFF_MASK)
		|-> rd_data_out == 32'($past(msk_r))) else $error("mask readback");
	a_irq_masked: assert property (
		irq_out |-> msk_r != 2'h0) else $error("irq with all masked");
	a_cap_irq: assert property (
		$rose(irq_out) && msk_r == 2'h1 && !$past(mw_c)
		|-> $past(capture_input_pin_in, 5) != $past(capture_input_pin_in, 6))
		else $error("capture irq without pin edge");
	a_stop_quiet: assert property (
		$rose(irq_out) |-> $past(run_r) || $past(mw_c))
		else $error("irq while stopped");
	a_clear_flags: assert property (
		wr_c && bus_in.addr == OFF_STATUS && bus_in.wdata[1:0] == 2'h3
		&& msk_r[1] == 1'b0
		&& $past(capture_input_pin_in, 4) == $past(capture_input_pin_in, 5)
		|=> !irq_out) else $error("irq after clear");
	a_cap_wide: assert property (
		$past(rd_c && bus_in.addr == OFF_CAPTURE)
		|-> rd_data_out[31:16] == 16'h0000) else $error("capture width");
	a_pin_read: assert property (
		$past(rd_c && bus_in.addr == OFF_PIN)
		|-> rd_data_out[31:1] == 31'h0) else $error("pin readback");
	a_pend_read: assert property (
		$past(rd_c && bus_in.addr == OFF_PENDING)
		|-> rd_data_out < 32'h3) else $error("pending code");
endmodule : hpwc_assertions

bind hpwc_top hpwc_assertions chk (
	.mclk_in(mclk_in),
	.rst_n_in(rst_n_in),
	.ce_in(ce_in),
	.bus_in(bus_in),
	.capture_input_pin_in(capture_input_pin_in),
	.rd_data_out(rd_data_out),
	.irq_out(irq_out)
);

`default_nettype wire

// *** verif/hpwc_pulse_src.sv ***
/*
 * hpwc_pulse_src: pulse source on the capture pin.
 * assumes: fire_in is a one-cycle request, len_in the high time.
 */
`default_nettype none

module hpwc_pulse_src
(
	input  wire logic       mclk_in,
	input  wire logic       fire_in,
	input  wire logic [7:0] len_in,
	output var  logic       pin_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_r = 8'h00;
	always @(posedge mclk_in)
	begin
		if (fire_in)
			left_r <= len_in;
		else if (left_r != 8'h00)
			left_r <= left_r - 8'h01;
	end
	assign pin_out = (left_r != 8'h00);
endmodule : hpwc_pulse_src

`default_nettype wire

// *** verif/tb.sv ***
/*
 * tb: self-checking bench of hpwc_top.
 * assumes: pulse source drives the pin; ce_in high but for one freeze check.
 */
`default_nettype none

module tb
	import hpwc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             mclk_in = 1'b0;
	logic             rst_n_in = 1'b0;
	hpwc_bus_req_type bus = '0;
	logic [31:0]      rdat;
	logic             pin;
	logic             irq;
	logic             ce = 1'b1;
	logic             fire = 1'b0;
	logic [7:0]       len = 8'h00;
	int               num_errors = 0;
	int               checked = 0;
	int               cyc = 0;
	always #2.5 mclk_in = ~mclk_in;
	hpwc_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
		.bus_in(bus), .capture_input_pin_in(pin), .rd_data_out(rdat),
		.irq_out(irq));
	hpwc_pulse_src src (.mclk_in(mclk_in), .fire_in(fire), .len_in(len),
		.pin_out(pin));
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge mclk_in);
		bus.wr <= 1'b0;
		@(posedge mclk_in);
	endtask : wr
	task automatic rv(input logic [7:0] a, output logic [31:0] v);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge mclk_in);
		bus.rd <= 1'b0;
		@(negedge mclk_in);
		v = rdat;
		@(posedge mclk_in);
	endtask : rv
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rv(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask : rc
	task automatic ic(input logic e);
		@(negedge mclk_in);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge mclk_in);
	endtask : ic
	task automatic pulse(input logic [7:0] l, input int w);
		fire <= 1'b1;
		len <= l;
		@(posedge mclk_in);
		fire <= 1'b0;
		repeat (w) @(posedge mclk_in);
	endtask : pulse
	task automatic t_regs();
		for (int a = 0; a <= 32; a += 4)
			rc(8'(a), 32'h0);
		wr(OFF_CAPTURE, 32'hABCD);
		rc(OFF_CAPTURE, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_count();
		wr(OFF_START, 32'h1);
		repeat (17) @(posedge mclk_in);
		rc(OFF_COUNT, 32'h4);
		rc(OFF_COUNT, 32'h5);
		ce <= 1'b0;
		repeat (8) @(posedge mclk_in);
		ce <= 1'b1;
		rc(OFF_COUNT, 32'h5);
		$display("test count done");
	endtask : t_count
	task automatic t_capture();
		wr(OFF_MASK, 32'h1);
		pulse(8'h15, 7);
		ic(1'b1);
		rc(OFF_PENDING, 32'h2);
		rc(OFF_PIN, 32'h1);
		rc(OFF_STATUS, 32'h1);
		wr(OFF_STATUS, 32'h3);
		ic(1'b0);
		repeat (10) @(posedge mclk_in);
		ic(1'b1);
		rc(OFF_CAPTURE, 32'h5);
		wr(OFF_STATUS, 32'h3);
		pulse(8'h02, 12);
		rc(OFF_STATUS, 32'h0);
		rc(OFF_CAPTURE, 32'h5);
		$display("test capture done");
	endtask : t_capture
	task automatic t_mask();
		wr(OFF_MASK, 32'h0);
		pulse(8'h09, 20);
		ic(1'b0);
		rc(OFF_STATUS, 32'h1);
		rc(OFF_CAPTURE, 32'h2);
		wr(OFF_MASK, 32'h1);
		rc(OFF_MASK, 32'h1);
		ic(1'b1);
		wr(OFF_STATUS, 32'h3);
		wr(OFF_START, 32'h0);
		pulse(8'h08, 12);
		rc(OFF_STATUS, 32'h0);
		$display("test mask done");
	endtask : t_mask
	task automatic serve(input logic [1:0] code, inout logic started,
		inout logic err, inout int ovf, inout logic [31:0] width);
		logic [31:0] v;
		@(negedge mclk_in);
		for (int i = 0; i < 64 && !irq; i++)
			@(negedge mclk_in);
		@(posedge mclk_in);
		rv(OFF_PENDING, v);
		chk("pending", {30'h0, code}, v);
		if (v[1:0] == PEND_OVF)
		begin
			rv(OFF_GROUP, v);
			if (v[GROUP_BIT] == 1'b0)
				err = 1'b1;
			else if (started)
				ovf++;
			if (ovf > 32'h0000FFFF)
				err = 1'b1;
			wr(OFF_STATUS, 32'h2);
		end
		else if (v[1:0] == PEND_CAP)
		begin
			rv(OFF_PIN, v);
			if (v[PIN_BIT])
			begin
				started = 1'b1;
				ovf = 0;
			end
			else if (started)
			begin
				rv(OFF_CAPTURE, v);
				width = 32'(ovf) * 32'h00010000 + v;
				started = 1'b0;
			end
			wr(OFF_STATUS, 32'h1);
		end
		else
			err = 1'b1;
	endtask : serve
	task automatic t_measure();
		logic [31:0] width;
		logic        started;
		logic        err;
		int          ovf;
		width = 32'h0;
		started = 1'b0;
		err = 1'b0;
		ovf = 0;
		wr(OFF_START, 32'h1);
		pulse(8'h29, 0);
		serve(PEND_CAP, started, err, ovf, width);
		serve(PEND_CAP, started, err, ovf, width);
		chk("width", 32'h0000000A, width);
		chk("error", 32'h0, {31'h0, err});
		$display("test measure done");
	endtask : t_measure
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		t_regs();
		t_count();
		t_capture();
		t_mask();
		t_measure();
		end_of_test();
	end
endmodule : tb

`default_nettype wire
